// >>> design/fgw_cfg.svh
// offsets, bit positions, sizes and limits of the gateway io map
`ifndef FGW_CFG_SVH
`define FGW_CFG_SVH

// cyclic image sizes in 16-bit words
`define FGW_RX_WORDS       10
`define FGW_RW_WORDS       24
`define FGW_PROC_WORDS     16
`define FGW_MSG_WORDS      2

// remote input word indices
`define FGW_RX_IDX_RSVD0   0
`define FGW_RX_IDX_STATUS  1

// status word bit positions
`define FGW_ST_CFG_OK      0
`define FGW_ST_ZERO_SLAVE  1
`define FGW_ST_AUTO_ASSIGN 2
`define FGW_ST_AUTO_AVAIL  3
`define FGW_ST_CFG_MODE    4
`define FGW_ST_NORMAL_OP   5
`define FGW_ST_PWR_FAIL    6
`define FGW_ST_OFFLINE     7
`define FGW_ST_NO_PERIPH   8
`define FGW_ST_LOW_VOLT    10
`define FGW_ST_EARTH       12
`define FGW_ST_OVERVOLT    13
`define FGW_ST_NOISE       14
`define FGW_ST_RSVD_MASK   16'h8a00

// first remote output word bit positions
`define FGW_RY_OFFLINE     0
`define FGW_RY_AUTO_ADDR   1
`define FGW_RY_CFG_ENTRY   2
`define FGW_RY_PROT_ENTRY  3
`define FGW_RY_CTRL_BITS   4

// circuit voltage thresholds in millivolts
`define FGW_PWR_FAIL_MV    16'd19000
`define FGW_LOW_VOLT_MV    16'd22500

// occupied stations and cycle setting per mode
`define FGW_STN_STANDARD   3'd3
`define FGW_STN_COMPAT1    3'd3
`define FGW_STN_COMPAT2    3'd4
`define FGW_STN_COMPAT3    3'd4
`define FGW_STN_COMPAT4    3'd2
`define FGW_CYC_DOUBLE     2'd2
`define FGW_CYC_SINGLE     2'd1
`define FGW_CIRCUITS       2'd1

// number of selectable modes
`define FGW_MODE_COUNT     3'd5

`endif

// >>> design/fgw_pkg.sv
// types shared by the gateway io map modules
package fgw_pkg;

    typedef enum logic [2:0] {
        FGW_MODE_STANDARD,
        FGW_MODE_COMPAT1,
        FGW_MODE_COMPAT2,
        FGW_MODE_COMPAT3,
        FGW_MODE_COMPAT4
    } fgw_mode_t;

    // circuit state from the master core
    typedef struct packed {
        logic cfg_ok;
        logic zero_addr_slave_seen;
        logic auto_addr_assign;
        logic auto_addr_avail;
        logic cfg_mode_active;
        logic normal_operation_flag;
        logic offline;
        logic no_periphery_fault;
        logic earth_fault_flag;
        logic overvoltage_flag;
        logic noise;
    } fgw_status_t;

    // commands towards the master core
    typedef struct packed {
        logic offline_request;
        logic auto_addressing_enable;
        logic cfg_mode_entry;
        logic protected_mode_entry;
    } fgw_ctrl_t;

    // properties of the selected transmission mode
    typedef struct packed {
        logic [2:0] stations;
        logic [1:0] cycle_setting;
        logic       analog_support;
        logic       net_config;
        logic       msg_channel;
        logic       buffer_mapping;
        logic [1:0] circuits;
    } fgw_caps_t;

endpackage : fgw_pkg

// >>> design/fgw_edge_det.sv
// rising edge finder on bits sampled once per fieldbus cycle
`timescale 1ns/1ps

module fgw_edge_det #(
    parameter int N = 2
) (
    input  wire logic         ref_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         sample_i,
    input  wire logic [N-1:0] bits_i,
    output logic      [N-1:0] rise_o
);

    typedef struct packed {
        logic [N-1:0] prev;
        logic [N-1:0] rise;
    } fgw_edge_state_t;

    fgw_edge_state_t state_q;
    fgw_edge_state_t state_d;

    always_comb begin
        state_d      = state_q;
        state_d.rise = '0;
        if (sample_i) begin
            // compare with previous cycle, one pulse per low-to-high
            state_d.rise = bits_i & ~state_q.prev;
            state_d.prev = bits_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rise_o = state_q.rise;

endmodule : fgw_edge_det

// >>> design/fgw_remote_io.sv
// cyclic remote io map and mode selection of the fieldbus gateway
//
// Summary of operation
// [RULE1] transmission mode chosen from local menu: standard or four compatibility modes
// [RULE2] standard mode occupies three stations with double cycle setting
// [RULE3] standard mode keeps final two cyclic words for message channel
// [RULE4] standard mode maps process data into the buffer area
// [RULE5] acyclic requests in standard mode travel through message words
// [RULE6] exactly one circuit served in every mode
// [RULE7] analog slaves only in standard and first two compatibility modes
// [RULE8] network configuration over fieldbus only in those same three modes
// [RULE9] input word zero reserved, word one status, words two to nine reserved
// [RULE10] status bits 0-5, 7, 8 report circuit and master state
// [RULE11] status bit 6 set while circuit voltage below 19 volts
// [RULE12] bit 10 low voltage below 22.5 V; 12-14 faults; 9,11,15 reserved
// [RULE13] output bit 0 offline, bit 1 auto addressing, bit 2 edge enters config
// [RULE14] output bit 3 edge enters protected mode; other bits and words reserved
// [RULE15] mode entry edges found against previous fieldbus cycle value
// [RULE16] reserved input bits and words read zero; reserved outputs ignored
`timescale 1ns/1ps
`include "fgw_cfg.svh"

module fgw_remote_io #(
    parameter int RX_WORDS   = `FGW_RX_WORDS,
    parameter int RW_WORDS   = `FGW_RW_WORDS,
    parameter int PROC_WORDS = `FGW_PROC_WORDS,
    parameter int MSG_WORDS  = `FGW_MSG_WORDS
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      sys_rst_i,
    input  wire logic [2:0]                menu_mode_i,
    input  wire logic                      menu_mode_set_i,
    input  wire logic                      cyc_strobe_i,
    input  wire logic [15:0]               remote_output_base_i,
    input  wire fgw_pkg::fgw_status_t      core_status_i,
    input  wire logic [15:0]               asi_voltage_mv_i,
    input  wire logic [RW_WORDS*16-1:0]    rw_write_i,
    input  wire logic [PROC_WORDS*16-1:0]  proc_in_i,
    input  wire logic [MSG_WORDS*16-1:0]   msg_tx_i,
    output logic      [RX_WORDS*16-1:0]    remote_input_base_o,
    output logic      [RW_WORDS*16-1:0]    rw_read_o,
    output logic      [PROC_WORDS*16-1:0]  process_buffer_area_o,
    output logic                           proc_valid_o,
    output logic      [MSG_WORDS*16-1:0]   msg_rx_o,
    output logic                           msg_valid_o,
    output fgw_pkg::fgw_ctrl_t             ctrl_o,
    output fgw_pkg::fgw_caps_t             caps_o,
    output fgw_pkg::fgw_mode_t             mode_o
);

    import fgw_pkg::*;

    localparam int MSG_BASE = RW_WORDS - MSG_WORDS;

    typedef struct packed {
        fgw_mode_t                 mode;
        fgw_caps_t                 caps;
        logic [RX_WORDS*16-1:0]    rx_image;
        logic [RW_WORDS*16-1:0]    rw_image;
        logic [PROC_WORDS*16-1:0]  proc_out;
        logic                      proc_valid;
        logic [MSG_WORDS*16-1:0]   msg_rx;
        logic                      msg_valid;
        fgw_ctrl_t                 ctrl;
    } fgw_state_t;

    fgw_state_t state_q;
    fgw_state_t state_d;

    logic [1:0]  entry_rise;
    logic [15:0] status_word;

    // capability decode, shared by reset value and mode change
    function automatic fgw_caps_t mode_caps(input fgw_mode_t m);
        fgw_caps_t c;
        c = '0;
        // [RULE6] single circuit
        c.circuits = `FGW_CIRCUITS;
        case (m)
            FGW_MODE_STANDARD: begin
                // [RULE2] three stations double cycle
                c.stations       = `FGW_STN_STANDARD;
                c.cycle_setting  = `FGW_CYC_DOUBLE;
                c.msg_channel    = 1'b1;
                c.buffer_mapping = 1'b1;
            end
            FGW_MODE_COMPAT1: begin
                c.stations      = `FGW_STN_COMPAT1;
                c.cycle_setting = `FGW_CYC_SINGLE;
            end
            FGW_MODE_COMPAT2: begin
                c.stations      = `FGW_STN_COMPAT2;
                c.cycle_setting = `FGW_CYC_SINGLE;
            end
            FGW_MODE_COMPAT3: begin
                c.stations      = `FGW_STN_COMPAT3;
                c.cycle_setting = `FGW_CYC_SINGLE;
            end
            FGW_MODE_COMPAT4: begin
                c.stations      = `FGW_STN_COMPAT4;
                c.cycle_setting = `FGW_CYC_SINGLE;
            end
            default: begin
                c.stations      = `FGW_STN_STANDARD;
                c.cycle_setting = `FGW_CYC_DOUBLE;
            end
        endcase
        // [RULE7] analog slaves limited
        c.analog_support = (m == FGW_MODE_STANDARD) || (m == FGW_MODE_COMPAT1) ||
                           (m == FGW_MODE_COMPAT2);
        // [RULE8] fieldbus configuration limited
        c.net_config     = c.analog_support;
        return c;
    endfunction : mode_caps

    // menu code to mode, out of range codes rejected
    function automatic fgw_mode_t code_to_mode(input logic [2:0] code, input fgw_mode_t keep);
        fgw_mode_t m;
        m = keep;
        case (code)
            3'h0:    m = FGW_MODE_STANDARD;
            3'h1:    m = FGW_MODE_COMPAT1;
            3'h2:    m = FGW_MODE_COMPAT2;
            3'h3:    m = FGW_MODE_COMPAT3;
            3'h4:    m = FGW_MODE_COMPAT4;
            default: m = keep;
        endcase
        return m;
    endfunction : code_to_mode

    // [RULE15] edges against previous cycle
    fgw_edge_det #(
        .N (2)
    ) u_entry_edges (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .sample_i  (cyc_strobe_i),
        .bits_i    (remote_output_base_i[`FGW_RY_PROT_ENTRY:`FGW_RY_CFG_ENTRY]),
        .rise_o    (entry_rise)
    );

    // status word from the single circuit
    always_comb begin
        status_word = 16'h0000;
        // [RULE10] circuit and master state
        status_word[`FGW_ST_CFG_OK]      = core_status_i.cfg_ok;
        status_word[`FGW_ST_ZERO_SLAVE]  = core_status_i.zero_addr_slave_seen;
        status_word[`FGW_ST_AUTO_ASSIGN] = core_status_i.auto_addr_assign;
        status_word[`FGW_ST_AUTO_AVAIL]  = core_status_i.auto_addr_avail;
        status_word[`FGW_ST_CFG_MODE]    = core_status_i.cfg_mode_active;
        status_word[`FGW_ST_NORMAL_OP]   = core_status_i.normal_operation_flag;
        status_word[`FGW_ST_OFFLINE]     = core_status_i.offline;
        status_word[`FGW_ST_NO_PERIPH]   = core_status_i.no_periphery_fault;
        // [RULE11] power fail below 19 V
        status_word[`FGW_ST_PWR_FAIL]    = asi_voltage_mv_i < `FGW_PWR_FAIL_MV;
        // [RULE12] warning and faults
        status_word[`FGW_ST_LOW_VOLT]    = asi_voltage_mv_i < `FGW_LOW_VOLT_MV;
        status_word[`FGW_ST_EARTH]       = core_status_i.earth_fault_flag;
        status_word[`FGW_ST_OVERVOLT]    = core_status_i.overvoltage_flag;
        status_word[`FGW_ST_NOISE]       = core_status_i.noise;
        // [RULE16] reserved bits forced low
        status_word = status_word & ~`FGW_ST_RSVD_MASK;
    end

    always_comb begin
        state_d            = state_q;
        state_d.proc_valid = 1'b0;
        state_d.msg_valid  = 1'b0;
        state_d.ctrl.cfg_mode_entry       = 1'b0;
        state_d.ctrl.protected_mode_entry = 1'b0;

        // [RULE1] menu selects the mode
        if (menu_mode_set_i) begin
            state_d.mode = code_to_mode(menu_mode_i, state_q.mode);
            state_d.caps = mode_caps(state_d.mode);
        end

        if (cyc_strobe_i) begin
            // [RULE9] only word one carries data
            state_d.rx_image = '0;
            state_d.rx_image[`FGW_RX_IDX_STATUS*16 +: 16] = status_word;

            // [RULE13] level commands
            state_d.ctrl.offline_request        = remote_output_base_i[`FGW_RY_OFFLINE];
            state_d.ctrl.auto_addressing_enable = remote_output_base_i[`FGW_RY_AUTO_ADDR] &
                                                  state_q.caps.net_config;

            state_d.rw_image = '0;
            if (state_q.caps.buffer_mapping) begin
                // [RULE4] process data to buffer area
                state_d.proc_out   = rw_write_i[PROC_WORDS*16-1:0];
                state_d.proc_valid = 1'b1;
                state_d.rw_image[PROC_WORDS*16-1:0] = proc_in_i;
            end
            if (state_q.caps.msg_channel) begin
                // [RULE3] final words carry messages
                // [RULE5] acyclic traffic tunnelled
                state_d.msg_rx    = rw_write_i[MSG_BASE*16 +: MSG_WORDS*16];
                state_d.msg_valid = 1'b1;
                state_d.rw_image[MSG_BASE*16 +: MSG_WORDS*16] = msg_tx_i;
            end
        end

        // [RULE13] config entry on rising edge
        if (entry_rise[0] && state_q.caps.net_config) begin
            state_d.ctrl.cfg_mode_entry = 1'b1;
        end
        // [RULE14] protected entry on rising edge
        if (entry_rise[1] && state_q.caps.net_config) begin
            state_d.ctrl.protected_mode_entry = 1'b1;
        end

        if (!state_q.caps.net_config) begin
            state_d.ctrl.auto_addressing_enable = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_q      <= '0;
            state_q.mode <= FGW_MODE_STANDARD;
            state_q.caps <= mode_caps(FGW_MODE_STANDARD);
        end else begin
            state_q <= state_d;
        end
    end

    assign remote_input_base_o   = state_q.rx_image;
    assign rw_read_o             = state_q.rw_image;
    assign process_buffer_area_o = state_q.proc_out;
    assign proc_valid_o          = state_q.proc_valid;
    assign msg_rx_o              = state_q.msg_rx;
    assign msg_valid_o           = state_q.msg_valid;
    assign ctrl_o                = state_q.ctrl;
    assign caps_o                = state_q.caps;
    assign mode_o                = state_q.mode;

endmodule : fgw_remote_io

// >>> testbench/fgw_remote_io_asserts.sv
// port checker of the remote io map, bound into the design
`timescale 1ns/1ps
module fgw_remote_io_asserts #(
    parameter int RX_WORDS  = 10,
    parameter int RW_WORDS  = 24,
    parameter int MSG_WORDS = 2
) (
    input wire logic                    ref_clk_i,
    input wire logic                    sys_rst_i,
    input wire logic                    cyc_strobe_i,
    input wire logic [15:0]             remote_output_base_i,
    input wire logic [15:0]             asi_voltage_mv_i,
    input wire logic [RW_WORDS*16-1:0]  rw_write_i,
    input wire logic [RX_WORDS*16-1:0]  remote_input_base_o,
    input wire logic                    proc_valid_o,
    input wire logic                    msg_valid_o,
    input wire logic [MSG_WORDS*16-1:0] msg_rx_o,
    input wire fgw_pkg::fgw_ctrl_t      ctrl_o,
    input wire fgw_pkg::fgw_caps_t      caps_o,
    input wire fgw_pkg::fgw_mode_t      mode_o
);
    import fgw_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_st_rsvd; (remote_input_base_o[31:16] & 16'h8a00) == 16'h0; endproperty
    a_st_rsvd: assert property (p_st_rsvd) else $error("reserved status bit set");
    property p_pwr; cyc_strobe_i |=> remote_input_base_o[22] == ($past(asi_voltage_mv_i) < 16'd19000); endproperty
    a_pwr: assert property (p_pwr) else $error("power fail flag wrong");
    property p_low; cyc_strobe_i |=> remote_input_base_o[26] == ($past(asi_voltage_mv_i) < 16'd22500); endproperty
    a_low: assert property (p_low) else $error("low voltage flag wrong");
    property p_off; cyc_strobe_i |=> ctrl_o.offline_request == $past(remote_output_base_i[0]); endproperty
    a_off: assert property (p_off) else $error("offline level wrong");
    property p_cfg; $rose(ctrl_o.cfg_mode_entry) |-> $past(cyc_strobe_i, 2) && $past(remote_output_base_i[2], 2)
        && $past(caps_o.net_config); endproperty
    a_cfg: assert property (p_cfg) else $error("config entry without cause");
    property p_prot; $rose(ctrl_o.protected_mode_entry) |-> $past(cyc_strobe_i, 2)
        && $past(remote_output_base_i[3], 2) && $past(caps_o.net_config); endproperty
    a_prot: assert property (p_prot) else $error("protected entry without cause");
    property p_once; ctrl_o.cfg_mode_entry |=> !ctrl_o.cfg_mode_entry; endproperty
    a_once: assert property (p_once) else $error("entry pulse too long");
    property p_std; mode_o == FGW_MODE_STANDARD |-> caps_o == {3'd3, 2'd2, 4'hf, 2'd1}; endproperty
    a_std: assert property (p_std) else $error("standard mode caps wrong");
    property p_caps; caps_o.circuits == 2'd1 && caps_o.analog_support == caps_o.net_config
        && caps_o.net_config == (mode_o inside {FGW_MODE_STANDARD, FGW_MODE_COMPAT1, FGW_MODE_COMPAT2}); endproperty
    a_caps: assert property (p_caps) else $error("mode caps wrong");
    property p_proc; proc_valid_o |-> $past(cyc_strobe_i) && $past(caps_o.buffer_mapping); endproperty
    a_proc: assert property (p_proc) else $error("process data outside buffer mode");
    property p_msg; msg_valid_o |-> $past(caps_o.msg_channel)
        && msg_rx_o == $past(rw_write_i[RW_WORDS*16-1 -: MSG_WORDS*16]); endproperty
    a_msg: assert property (p_msg) else $error("message words wrong");
    c_cfg: cover property (ctrl_o.cfg_mode_entry);
    c_prot: cover property (ctrl_o.protected_mode_entry);
    c_msg: cover property (msg_valid_o && proc_valid_o);
endmodule : fgw_remote_io_asserts

bind fgw_remote_io fgw_remote_io_asserts #(.RX_WORDS(RX_WORDS), .RW_WORDS(RW_WORDS), .MSG_WORDS(MSG_WORDS))
    u_fgw_remote_io_asserts (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cyc_strobe_i(cyc_strobe_i),
    .remote_output_base_i(remote_output_base_i), .asi_voltage_mv_i(asi_voltage_mv_i), .rw_write_i(rw_write_i),
    .remote_input_base_o(remote_input_base_o), .proc_valid_o(proc_valid_o), .msg_valid_o(msg_valid_o),
    .msg_rx_o(msg_rx_o), .ctrl_o(ctrl_o), .caps_o(caps_o), .mode_o(mode_o));

// >>> testbench/fgw_master_model.sv
// cyclic master model: strobe cadence, control word and register image
`timescale 1ns/1ps
module fgw_master_model (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [3:0]  gap_i,
    input  wire logic [15:0] ry_i,
    output logic             cyc_strobe_o,
    output logic [15:0]      ry_o,
    output logic [383:0]     rw_o
);
    logic [3:0]  cnt_q;
    logic [15:0] seq_q;
    always_ff @(posedge ref_clk_i) begin
        cnt_q        <= (sys_rst_i || cnt_q >= gap_i) ? 4'h0 : cnt_q + 4'h1;
        cyc_strobe_o <= !sys_rst_i && cnt_q >= gap_i;
        ry_o         <= sys_rst_i ? 16'h0 : ry_i;
        seq_q        <= sys_rst_i ? 16'h0 : seq_q + 16'h1;
    end
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            rw_o[16*i +: 16] = seq_q ^ (16'h1111 * 16'(i));
        end
    end
endmodule : fgw_master_model

// >>> testbench/fgw_remote_io_tb.sv
// self-checking bench of the remote io map against the master model
`timescale 1ns/1ps
module fgw_remote_io_tb;
    import fgw_pkg::*;
    typedef struct packed {
        logic [10:0] st;
        logic [15:0] v;
        logic [15:0] ry;
        logic [15:0] w;
        logic [1:0]  lv;
    } fgw_row_t;
    fgw_row_t     rows [6] = '{'{11'h000, 16'd18999, 16'hfff1, 16'h0440, 2'b10},
        '{11'h000, 16'd19000, 16'hfff2, 16'h0400, 2'b01}, '{11'h000, 16'd22499, 16'h0003, 16'h0400, 2'b11},
        '{11'h000, 16'd22500, 16'h0000, 16'h0000, 2'b00}, '{11'h555, 16'd30000, 16'h0000, 16'h5095, 2'b00},
        '{11'h2aa, 16'd30000, 16'h0000, 16'h212a, 2'b00}};
    logic [10:0]  caps_exp [5] = '{11'h3bd, 11'h371, 11'h471, 11'h441, 11'h241};
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic [2:0]   code = 3'h0;
    logic         set = 1'b0;
    logic [3:0]   gap = 4'h7;
    logic [15:0]  ry_drv = 16'h0;
    fgw_status_t  sts = '0;
    logic [15:0]  volt = 16'd30000;
    logic [15:0]  ry;
    logic         stb;
    logic [383:0] rw;
    logic [383:0] snap;
    logic [159:0] rx;
    logic [383:0] rw_rd;
    logic [255:0] pba;
    logic [31:0]  msg;
    logic         pv;
    logic         mv;
    fgw_ctrl_t    ctrl;
    fgw_caps_t    caps;
    fgw_mode_t    mode;
    int           fails = 0;
    int           check_count = 0;
    int           n_cfg = 0;
    int           n_prot = 0;
    int           n_pv = 0;
    int           b_cfg;
    int           b_pv;

    fgw_master_model u_fgw_master_model (.ref_clk_i(clk), .sys_rst_i(rst), .gap_i(gap), .ry_i(ry_drv),
        .cyc_strobe_o(stb), .ry_o(ry), .rw_o(rw));
    fgw_remote_io u_fgw_remote_io (.ref_clk_i(clk), .sys_rst_i(rst), .menu_mode_i(code), .menu_mode_set_i(set),
        .cyc_strobe_i(stb), .remote_output_base_i(ry), .core_status_i(sts), .asi_voltage_mv_i(volt),
        .rw_write_i(rw), .proc_in_i({16{16'h5a5a}}), .msg_tx_i(32'hc3c3_3c3c), .remote_input_base_o(rx),
        .rw_read_o(rw_rd), .process_buffer_area_o(pba), .proc_valid_o(pv), .msg_valid_o(mv), .msg_rx_o(msg),
        .ctrl_o(ctrl), .caps_o(caps), .mode_o(mode));

    always #20 clk = ~clk;
    always @(negedge clk) begin
        if (ctrl.cfg_mode_entry === 1'b1) n_cfg++;
        if (ctrl.protected_mode_entry === 1'b1) n_prot++;
        if (pv === 1'b1) n_pv++;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    // set control word, then wait n strobes
    task automatic cyc(input logic [15:0] r, input int n);
        int t;
        @(posedge clk);
        ry_drv <= r;
        repeat (n) begin
            t = 0;
            do begin
                @(negedge clk);
                t++;
            end while (stb !== 1'b1 && t < 40);
            if (t >= 40) begin
                fails++;
                end_sim();
            end
            snap = rw;
        end
        @(negedge clk);
    endtask : cyc

    task automatic set_mode(input logic [2:0] c);
        @(posedge clk);
        code <= c;
        set  <= 1'b1;
        @(posedge clk);
        set  <= 1'b0;
        @(negedge clk);
    endtask : set_mode

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(16'(mode), 16'(FGW_MODE_STANDARD));
        chk(16'(caps), 16'h03bd);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            sts  <= fgw_status_t'(rows[i].st);
            volt <= rows[i].v;
            cyc(rows[i].ry, 2);
            chk(rx[31:16], rows[i].w);
            chk(16'({ctrl.offline_request, ctrl.auto_addressing_enable}), 16'(rows[i].lv));
            chk(16'({rx[159:32], rx[15:0]} != '0), 16'h0);
        end
        $display("test status rows done");
        @(posedge clk);
        gap <= 4'h0;
        cyc(16'h0, 3);
        b_cfg = n_cfg;
        b_pv  = n_prot;
        cyc(16'h4, 3);
        cyc(16'hc, 3);
        cyc(16'h0, 3);
        chk(16'(n_cfg - b_cfg), 16'h1);
        chk(16'(n_prot - b_pv), 16'h1);
        chk(msg[15:0], snap[367:352]);
        chk(msg[31:16], snap[383:368]);
        chk(16'(mv), 16'h1);
        chk(16'(n_pv > 0), 16'h1);
        chk(pba[15:0], snap[15:0]);
        chk(16'(rw_rd[351:256] != '0), 16'h0);
        chk(rw_rd[367:352], 16'h3c3c);
        $display("test edges done");
        for (int i = 0; i < 5; i++) begin
            set_mode(3'(i));
            chk(16'(mode), 16'(i));
            chk(16'(caps), 16'(caps_exp[i]));
        end
        set_mode(3'h5);
        chk(16'(mode), 16'h4);
        b_cfg = n_cfg;
        b_pv  = n_pv;
        cyc(16'h0, 3);
        cyc(16'h6, 3);
        chk(16'({ctrl.offline_request, ctrl.auto_addressing_enable}), 16'h0);
        cyc(16'h0, 3);
        chk(16'(n_cfg - b_cfg), 16'h0);
        chk(16'(n_pv - b_pv), 16'h0);
        chk(16'(rw_rd != '0), 16'h0);
        $display("test modes done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(16'(mode), 16'(FGW_MODE_STANDARD));
        chk(16'(caps), 16'h03bd);
        chk(16'(rx != '0), 16'h0);
        $display("test mid reset done");
        end_sim();
    end
endmodule : fgw_remote_io_tb
